//--- common/gio_pkg.sv
// Constants and carrier types for the global pin control block.
// Assumes a 32-bit AXI4-Lite register bus and 30 shareable pins.
package gio_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned GIO_NPINS = 30;
    localparam int unsigned GIO_AW    = 8;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [GIO_AW-1:0] GIO_OFF_OWN   = 8'h00;
    localparam logic [GIO_AW-1:0] GIO_OFF_OE    = 8'h04;
    localparam logic [GIO_AW-1:0] GIO_OFF_OD    = 8'h08;
    localparam logic [GIO_AW-1:0] GIO_OFF_VALUE = 8'h0c;
    localparam logic [GIO_AW-1:0] GIO_OFF_READ  = 8'h10;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [GIO_NPINS-1:0] GIO_RST_OWN   = 30'h00000000;
    localparam logic [GIO_NPINS-1:0] GIO_RST_OE    = 30'h00000000;
    localparam logic [GIO_NPINS-1:0] GIO_RST_OD    = 30'h00000000;
    localparam logic [GIO_NPINS-1:0] GIO_RST_VALUE = 30'h00000000;

    // ------------------------------------------------------------
    // Pin bit positions
    // ------------------------------------------------------------
    localparam int unsigned GIO_BIT_PULSE_OUT_0A   = 0;
    localparam int unsigned GIO_BIT_PULSE_OUT_3B   = 7;
    localparam int unsigned GIO_BIT_SYNC           = 8;
    localparam int unsigned GIO_BIT_FAULT_0        = 9;
    localparam int unsigned GIO_BIT_FAULT_2        = 11;
    localparam int unsigned GIO_BIT_EXTERNAL_INTERRUPT = 12;
    localparam int unsigned GIO_BIT_ALERT          = 13;
    localparam int unsigned GIO_BIT_CONTROL        = 14;
    localparam int unsigned GIO_BIT_BUS_DATA       = 15;
    localparam int unsigned GIO_BIT_BUS_CLOCK      = 16;
    localparam int unsigned GIO_BIT_TIMER_PULSE_0  = 17;
    localparam int unsigned GIO_BIT_TIMER_PULSE_1  = 18;
    localparam int unsigned GIO_BIT_TIMER_CAPTURE  = 19;
    localparam int unsigned GIO_BIT_UART_RECEIVE_0 = 20;
    localparam int unsigned GIO_BIT_UART_RECEIVE_1 = 21;
    localparam int unsigned GIO_BIT_UART_TRANSMIT_0 = 22;
    localparam int unsigned GIO_BIT_UART_TRANSMIT_1 = 23;
    localparam int unsigned GIO_BIT_JTAG_TDI       = 24;
    localparam int unsigned GIO_BIT_JTAG_TMS       = 25;
    localparam int unsigned GIO_BIT_JTAG_TDO       = 26;
    localparam int unsigned GIO_BIT_JTAG_TCK       = 27;
    localparam int unsigned GIO_BIT_CONV_TRIGGER   = 28;
    localparam int unsigned GIO_BIT_FAULT_3        = 29;

    // ------------------------------------------------------------
    // AXI response codes
    // ------------------------------------------------------------
    localparam logic [1:0] GIO_RESP_OKAY   = 2'h0;
    localparam logic [1:0] GIO_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // One group of pad controls: what the pad drives and whether it drives
    typedef struct packed
    {
        logic [GIO_NPINS-1:0] out;
        logic [GIO_NPINS-1:0] oe;
    } gio_pad_drive_t;

    typedef struct packed
    {
        logic [1:0]  resp;
        logic [31:0] data;
    } gio_rd_answer_t;

endpackage : gio_pkg

//--- core/gio_global_pin_control.sv
// Global pin ownership and general purpose control for 30 digital pins.
// Assumes pad inputs are synchronous to clk and that each peripheral
// hands over its own out/oe pair for the pin it shares.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module gio_global_pin_control
    import gio_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rstn,
    // AXI4-Lite slave
    input  wire logic [GIO_AW-1:0]          s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output var  logic                       s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output var  logic                       s_axi_wready,
    output var  logic [1:0]                 s_axi_bresp,
    output var  logic                       s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [GIO_AW-1:0]          s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output var  logic                       s_axi_arready,
    output var  logic [31:0]                s_axi_rdata,
    output var  logic [1:0]                 s_axi_rresp,
    output var  logic                       s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // Peripheral side of each shared pin
    input  wire gio_pad_drive_t             periph_drive,
    output var  logic [GIO_NPINS-1:0]       periph_pin_in,
    // Pads
    input  wire logic [GIO_NPINS-1:0]       pad_in,
    output var  gio_pad_drive_t             pad_drive
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [GIO_NPINS-1:0] own_r;
    logic [GIO_NPINS-1:0] oe_r;
    logic [GIO_NPINS-1:0] od_r;
    logic [GIO_NPINS-1:0] value_r;
    logic [GIO_NPINS-1:0] pin_level_r;

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    logic [GIO_AW-1:0] wr_addr_r;
    logic [31:0]       wr_data_r;
    logic [3:0]        wr_strb_r;
    logic              aw_held_r;
    logic              w_held_r;
    logic              wr_fire;

    // Both halves held and no response pending: perform the write
    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            aw_held_r <= 1'b0;
            wr_addr_r <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_r <= 1'b1;
            wr_addr_r <= s_axi_awaddr;
        end
        else if (wr_fire)
        begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            w_held_r  <= 1'b0;
            wr_data_r <= '0;
            wr_strb_r <= '0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_r  <= 1'b1;
            wr_data_r <= s_axi_wdata;
            wr_strb_r <= s_axi_wstrb;
        end
        else if (wr_fire)
        begin
            w_held_r <= 1'b0;
        end
    end

    // A half is taken only while none of it is held and no answer is pending,
    // so a second write cannot slip in behind an unread response
    logic aw_held_nxt;
    logic w_held_nxt;
    logic bvalid_nxt;

    always_comb
    begin
        aw_held_nxt = (aw_held_r && !wr_fire) || (s_axi_awvalid && s_axi_awready);
        w_held_nxt  = (w_held_r && !wr_fire) || (s_axi_wvalid && s_axi_wready);
        bvalid_nxt  = wr_fire || (s_axi_bvalid && !s_axi_bready);
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s_axi_awready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_held_nxt && !bvalid_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_wready <= !w_held_nxt && !bvalid_nxt;
        end
    end

    function automatic logic addr_known(input logic [GIO_AW-1:0] a);
        addr_known = (a == GIO_OFF_OWN) || (a == GIO_OFF_OE) || (a == GIO_OFF_OD)
                  || (a == GIO_OFF_VALUE) || (a == GIO_OFF_READ);
    endfunction : addr_known

    // Byte-lane merge of a 30-bit register
    function automatic logic [GIO_NPINS-1:0] merge(
        input logic [GIO_NPINS-1:0] old,
        input logic [31:0]          data,
        input logic [3:0]           strb
    );
        logic [31:0] tmp;
        tmp = {2'h0, old};
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                tmp[i*8 +: 8] = data[i*8 +: 8];
        end
        merge = tmp[GIO_NPINS-1:0];
    endfunction : merge

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s_axi_bvalid <= 1'b0;
        end
        else
        begin
            s_axi_bvalid <= bvalid_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s_axi_bresp <= GIO_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            // The read register takes no write
            s_axi_bresp <= addr_known(wr_addr_r) && (wr_addr_r != GIO_OFF_READ) ? GIO_RESP_OKAY : GIO_RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            own_r   <= GIO_RST_OWN;
            oe_r    <= GIO_RST_OE;
            od_r    <= GIO_RST_OD;
            value_r <= GIO_RST_VALUE;
        end
        else if (wr_fire)
        begin
            unique case (wr_addr_r)
                GIO_OFF_OWN:   own_r   <= merge(own_r, wr_data_r, wr_strb_r);
                GIO_OFF_OE:    oe_r    <= merge(oe_r, wr_data_r, wr_strb_r);
                GIO_OFF_OD:    od_r    <= merge(od_r, wr_data_r, wr_strb_r);
                GIO_OFF_VALUE: value_r <= merge(value_r, wr_data_r, wr_strb_r);
                default:       ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic rd_take;

    assign rd_take = s_axi_arvalid && s_axi_arready;

    // One read at a time: the address waits until the answer is taken
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s_axi_arready <= 1'b0;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !rd_take;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s_axi_rvalid <= 1'b0;
        end
        else if (rd_take)
        begin
            s_axi_rvalid <= 1'b1;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s_axi_rresp <= GIO_RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_axi_rresp <= addr_known(s_axi_araddr) ? GIO_RESP_OKAY : GIO_RESP_SLVERR;
        end
    end

    // Data is frozen from one take to the next, so a slow master reads it intact
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s_axi_rdata <= '0;
        end
        else if (rd_take)
        begin
            unique case (s_axi_araddr)
                GIO_OFF_OWN:   s_axi_rdata <= {2'h0, own_r};
                GIO_OFF_OE:    s_axi_rdata <= {2'h0, oe_r};
                GIO_OFF_OD:    s_axi_rdata <= {2'h0, od_r};
                GIO_OFF_VALUE: s_axi_rdata <= {2'h0, value_r};
                GIO_OFF_READ:  s_axi_rdata <= {2'h0, pin_level_r};
                default:       s_axi_rdata <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin muxing
    // ------------------------------------------------------------
    // Only the 30 shareable digital pins exist here; power, analog and
    // reset pads have no path through this block.
    // Bit order of every vector follows the pin map.
    // Per pin: the global value where ownership is set, the peripheral's otherwise
    function automatic logic [GIO_NPINS-1:0] owner_mux(
        input logic [GIO_NPINS-1:0] own,
        input logic [GIO_NPINS-1:0] from_global,
        input logic [GIO_NPINS-1:0] from_periph
    );
        owner_mux = (own & from_global) | (~own & from_periph);
    endfunction : owner_mux

    logic [GIO_NPINS-1:0] glb_out;
    logic [GIO_NPINS-1:0] glb_oe;

    // Open drain only pulls low; a high is released to the pull-up
    assign glb_out = value_r & ~od_r;
    assign glb_oe  = oe_r & (~od_r | ~value_r);

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pad_drive <= '0;
        end
        else
        begin
            pad_drive.out <= owner_mux(own_r, glb_out, periph_drive.out);
            pad_drive.oe  <= owner_mux(own_r, glb_oe, periph_drive.oe);
        end
    end

    // Level is sampled regardless of owner so firmware may watch any pin
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pin_level_r <= '0;
        end
        else
        begin
            pin_level_r <= pad_in;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            periph_pin_in <= '0;
        end
        else
        begin
            periph_pin_in <= pad_in;
        end
    end

endmodule : gio_global_pin_control

`default_nettype wire

//--- tb/gio_pin_partner.sv
// Pin model: board pull-ups plus an outside driver on each pad.
// Assumes the bench never drives a pad that the block drives.
`timescale 1ns/1ps
`default_nettype none
module gio_pin_partner
    import gio_pkg::*;
(
    input  wire gio_pad_drive_t       pad_drive,
    input  wire logic [GIO_NPINS-1:0] ext_en,
    input  wire logic [GIO_NPINS-1:0] ext_val,
    output wire logic [GIO_NPINS-1:0] pad_in
);
    // A released line is pulled high, so open drain reads back as one
    assign pad_in = (pad_drive.oe & pad_drive.out) | (~pad_drive.oe & ((ext_en & ext_val) | ~ext_en));
endmodule : gio_pin_partner
`default_nettype wire

//--- tb/gio_pin_control_assertions.sv
// Bus handshake and pin checks on the global pin control block.
// Bound to the design top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module gio_pin_control_assertions
    import gio_pkg::*;
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [29:0] periph_pin_in,
    input wire logic [29:0] pad_in
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_write_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while busy");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while busy");
    a_upper_bits: assert property (s_axi_rvalid |-> s_axi_rdata[31:30] == 2'h0)
        else $error("unused read bits set");
    a_pin_input: assert property (rstn && $past(rstn) |-> periph_pin_in == $past(pad_in))
        else $error("pin level not passed on");
endmodule : gio_pin_control_assertions
bind gio_global_pin_control gio_pin_control_assertions gio_pin_control_assertions_inst (
    .clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .periph_pin_in, .pad_in
);
`default_nettype wire

//--- tb/tb_global_io_pin_control.sv
// Self-checking bench: a register bus master and a pin model.
// Assumes the design answers every request within the watchdog span.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
    begin check_count++; if ((a) !== (e)) \
    begin bad_count++; $display("mismatch %0t got %h want %h", $time, a, e); end end
module tb_global_io_pin_control
    import gio_pkg::*;
;
    logic           clk = 1'b0, rstn = 1'b0;
    logic [7:0]     s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0]    s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]     s_axi_wstrb = 4'hf;
    logic           s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic           s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic           s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]     s_axi_bresp, s_axi_rresp;
    logic [29:0]    periph_pin_in, ext_en = 30'h0, ext_val = 30'h0;
    wire  [29:0]    pad_in;
    gio_pad_drive_t periph_drive = '0, pad_drive;
    int             bad_count = 0, check_count = 0;
    always #5 clk = ~clk;
    gio_global_pin_control gio_global_pin_control_inst (
        .clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .periph_drive, .periph_pin_in, .pad_in, .pad_drive);
    gio_pin_partner gio_pin_partner_inst (.pad_drive, .ext_en, .ext_val, .pad_in);
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] pend;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        pend = 2'b11;
        // Address and data may be taken on different edges
        while (pend != 2'b00)
        begin
            @(posedge clk);
            pend = pend & ~{s_axi_awready, s_axi_wready};
            s_axi_awvalid <= pend[1];
            s_axi_wvalid <= pend[0];
        end
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b1;
        @(posedge clk);
        `CHK(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        // Late ready keeps the answer waiting for a cycle
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge clk);
        `CHK(s_axi_rdata, e);
        `CHK(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic t_regs();
        for (int i = 0; i < 4; i++)
            rd(8'(4 * i), 32'h0, GIO_RESP_OKAY);
        rd(8'h14, 32'h0, GIO_RESP_SLVERR);
        wr(GIO_OFF_READ, 32'h1, GIO_RESP_SLVERR);
        wr(GIO_OFF_OWN, 32'hffffffff, GIO_RESP_OKAY);
        rd(GIO_OFF_OWN, 32'h3fffffff, GIO_RESP_OKAY);
        // Only byte lane 1 is written
        s_axi_wstrb <= 4'h2;
        wr(GIO_OFF_OWN, 32'h0, GIO_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(GIO_OFF_OWN, 32'h3fff00ff, GIO_RESP_OKAY);
    endtask : t_regs
    task automatic t_drive();
        logic [29:0] m;
        wr(GIO_OFF_OE, 32'h3fffffff, GIO_RESP_OKAY);
        wr(GIO_OFF_VALUE, 32'h2aaaaaaa, GIO_RESP_OKAY);
        periph_drive <= '{out: 30'h15555555, oe: 30'h3ff0f0ff};
        for (int i = 0; i < 3; i++)
        begin
            m = (i == 0) ? 30'h0 : (i == 1) ? 30'h0001ffff : 30'h3ffe0000;
            wr(GIO_OFF_OWN, {2'h0, m}, GIO_RESP_OKAY);
            repeat (3) @(posedge clk);
            `CHK(pad_drive.out, (30'h2aaaaaaa & m) | (periph_drive.out & ~m));
            `CHK(pad_drive.oe, m | (periph_drive.oe & ~m));
            `CHK(periph_pin_in, pad_in);
        end
    endtask : t_drive
    task automatic t_pins();
        wr(GIO_OFF_OWN, 32'h3fffffff, GIO_RESP_OKAY);
        wr(GIO_OFF_OE, 32'h0, GIO_RESP_OKAY);
        ext_val <= 30'h0f0f0f0f;
        ext_en <= 30'h3fffffff;
        repeat (3) @(posedge clk);
        `CHK(pad_drive.oe, 30'h0);
        rd(GIO_OFF_READ, 32'h0f0f0f0f, GIO_RESP_OKAY);
        ext_en <= 30'h0;
        wr(GIO_OFF_OE, 32'h3fffffff, GIO_RESP_OKAY);
        wr(GIO_OFF_OD, 32'h3fffffff, GIO_RESP_OKAY);
        repeat (3) @(posedge clk);
        `CHK(pad_drive.oe, ~30'h2aaaaaaa);
        `CHK(pad_drive.out & pad_drive.oe, 30'h0);
        rd(GIO_OFF_READ, 32'h2aaaaaaa, GIO_RESP_OKAY);
    endtask : t_pins
    task automatic t_reset();
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(GIO_OFF_OWN, 32'h0, GIO_RESP_OKAY);
        rd(GIO_OFF_VALUE, 32'h0, GIO_RESP_OKAY);
        `CHK(pad_drive.out, periph_drive.out);
        `CHK(pad_drive.oe, periph_drive.oe);
    endtask : t_reset
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize
    initial
    begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_drive();
        t_pins();
        t_reset();
        summarize();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        bad_count++;
        summarize();
    end
endmodule : tb_global_io_pin_control
`default_nettype wire
